// ### hdl/rss_params.svh
// Constants for the reset source combiner and reset cause status block.
`ifndef RSS_PARAMS_SVH
`define RSS_PARAMS_SVH

`define RSS_DATA_W        16
`define RSS_ADDR_W        4
`define RSS_IDX_CAUSE     4'h0
`define RSS_IDX_LOWPWR    4'h1
`define RSS_IDX_SOURCES   4'h2
`define RSS_IDX_CONTROLS  4'h3

`define RSS_BIT_TRAP      15
`define RSS_BIT_ILLOP     14
`define RSS_BIT_HOLD      12
`define RSS_BIT_DSLEEP    10
`define RSS_BIT_CFGMIS    9
`define RSS_BIT_FBIAS     8
`define RSS_BIT_PIN       7
`define RSS_BIT_SOFT      6
`define RSS_BIT_WDEN      5
`define RSS_BIT_WATCHDOG_TIMEOUT_FLAG      4
`define RSS_BIT_SLEEP     3
`define RSS_BIT_IDLE      2
`define RSS_BIT_BROWN     1
`define RSS_BIT_POWER     0

`define RSS_CAUSE_POR_VAL 16'h0003
`define RSS_CAUSE_MASK    16'hD7FF

`define RSS_LP_BIT_VDDBOR 3
`define RSS_LP_BIT_VDDPOR 2
`define RSS_LP_BIT_VBPOR  1
`define RSS_LP_BIT_VBEXIT 0
`define RSS_LP_POR_VAL    4'hE

`define RSS_CLK_PS        5000
`define RSS_REL_NS        100
`define RSS_REL_CYCLES    ((`RSS_REL_NS * 1000 + `RSS_CLK_PS - 1) / `RSS_CLK_PS)
`define RSS_CNT_W         5

`endif

// ### hdl/rss_pkg.sv
// Types shared by the reset source combiner and its helpers.
`include "rss_params.svh"

package rss_pkg;

  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] sync;
  } rss_sync_s;

  typedef struct packed {
    logic                  active;
    logic [`RSS_CNT_W-1:0] cnt;
  } rss_stretch_s;

  typedef struct packed {
    logic [`RSS_DATA_W-1:0] cause;
    logic [3:0]             lowpwr;
    logic [`RSS_DATA_W-1:0] rdata;
    logic                   hold_en;
    logic                   fbias_keep;
    logic                   wdt_en;
  } rss_state_s;

endpackage

// ### hdl/rss_sync.sv
// Two-stage synchroniser for the two asynchronous source pins.
`timescale 1ns/1ps
`default_nettype none

module rss_sync
  import rss_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [1:0] async_in,
  output logic      [1:0] sync_out
);

  rss_sync_s state_reg;
  rss_sync_s state_next;

  always_comb begin
    state_next      = state_reg;
    state_next.meta = async_in;
    state_next.sync = state_reg.meta;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_out = state_reg.sync;

endmodule

`default_nettype wire

// ### hdl/rss_stretch.sv
// Holds the master reset while any source is active and for a release time after.
`timescale 1ns/1ps
`default_nettype none
`include "rss_params.svh"

module rss_stretch
  import rss_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic any_source,
  output logic      reset_out
);

  localparam logic [`RSS_CNT_W-1:0] REL_CNT = `RSS_CNT_W'(`RSS_REL_CYCLES);

  rss_stretch_s state_reg;
  rss_stretch_s state_next;

  always_comb begin
    state_next = state_reg;
    if (any_source) begin
      state_next.cnt    = REL_CNT;
      state_next.active = 1'b1;
    end else if (state_reg.cnt != '0) begin
      state_next.cnt    = state_reg.cnt - `RSS_CNT_W'(1);
      state_next.active = 1'b1;
    end else begin
      state_next.active = 1'b0;
    end
  end

  // Release is counted on the system clock, so the reset never drops mid-cycle.
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg.active <= 1'b1;
      state_reg.cnt    <= REL_CNT;
    end else begin
      state_reg <= state_next;
    end
  end

  assign reset_out = state_reg.active;

endmodule

`default_nettype wire

// ### hdl/rss_top.sv
// Reset source combiner with the reset cause and low-power reset status registers.
//
// Overview of operation
// - Nine reset sources are accepted, power-on reset being the rst input.
// - Any active reset source drives the master reset output.
// - Status and control bits are reinitialised on power-on only, not on other resets.
// - Each reset kind sets a flag in the reset cause register.
// - Brown-out during battery backup also sets a flag in the low-power status register.
// - Power-on clears the cause register except brown-out and power-on flags, set.
// - Software may set or clear flags; a software-set flag causes no reset.
// - Trap conflict reset sets bit 15.
// - Illegal opcode, addressing mode or uninitialised register reset sets bit 14.
// - Bit 12 enables retention on the 1.2V regulator during sleep.
// - Unprogrammed retention fuse disables retention whatever bit 12 says.
// - Bit 10 records that the device has been in deep sleep.
// - Configuration mismatch reset sets bit 9.
// - Bit 8 keeps flash bias powered during sleep when set.
// - Master clear pin reset sets bit 7.
// - Software reset instruction sets bit 6.
// - Unprogrammed watchdog fuse keeps the watchdog running regardless of bit 5.
// - Bits 13 and 11 ignore writes and read as zero.
// - Bit 5 enables the watchdog in software.
// - Watchdog time-out sets bit 4.
// - Bit 1 set by brown-out and power-on; bit 0 set by power-on.
`timescale 1ns/1ps
`default_nettype none
`include "rss_params.svh"

module rss_top
  import rss_pkg::*;
(
  input  wire logic                   mclk,
  input  wire logic                   rst,
  input  wire logic                   master_clear_pin_n,
  input  wire logic                   brownout_detect,
  input  wire logic                   soft_reset_req,
  input  wire logic                   watchdog_timeout,
  input  wire logic                   config_mismatch,
  input  wire logic                   trap_conflict,
  input  wire logic                   illegal_opcode,
  input  wire logic                   uninit_wreg_reset,
  input  wire logic                   sleep_enter,
  input  wire logic                   idle_enter,
  input  wire logic                   deep_sleep_en,
  input  wire logic                   wdt_clear,
  input  wire logic                   battery_backup_active,
  input  wire logic                   battery_por_event,
  input  wire logic                   battery_exit_event,
  input  wire logic                   retention_regulator_fuse,
  input  wire logic                   watchdog_fuse_enable,
  input  wire logic [`RSS_ADDR_W-1:0] reg_addr,
  input  wire logic [`RSS_DATA_W-1:0] reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [`RSS_DATA_W-1:0] reg_rdata,
  output logic                        master_reset,
  output logic                        low_voltage_hold_enable,
  output logic                        flash_bias_sleep_keep,
  output logic                        watchdog_enable
);

  rss_state_s state_reg;
  rss_state_s state_next;

  logic [1:0] pin_raw;
  logic [1:0] pin_sync;
  logic       pin_reset;
  logic       brownout;
  logic       illegal_any;
  logic       any_source;
  logic       wr_cause;
  logic       wr_lowpwr;
  logic       stretch_out;

  // Both pins are asynchronous to mclk; the master clear pin is active low.
  assign pin_raw[0] = ~master_clear_pin_n;
  assign pin_raw[1] = brownout_detect;

  rss_sync u_sync (
    .mclk     (mclk),
    .rst      (rst),
    .async_in (pin_raw),
    .sync_out (pin_sync)
  );

  assign pin_reset   = pin_sync[0];
  assign brownout    = pin_sync[1];
  assign illegal_any = illegal_opcode | uninit_wreg_reset;

  // Only the live sources feed the master reset, never the stored flags.
  assign any_source = rst | pin_reset | brownout | soft_reset_req | watchdog_timeout
                    | config_mismatch | trap_conflict | illegal_any;

  rss_stretch u_stretch (
    .mclk       (mclk),
    .rst        (rst),
    .any_source (any_source),
    .reset_out  (stretch_out)
  );

  assign wr_cause  = reg_wr && (reg_addr == `RSS_IDX_CAUSE);
  assign wr_lowpwr = reg_wr && (reg_addr == `RSS_IDX_LOWPWR);

  always_comb begin
    state_next       = state_reg;
    state_next.rdata = '0;

    // Software writes first, so that a hardware event in the same cycle wins.
    if (wr_cause) begin
      state_next.cause = reg_wdata & `RSS_CAUSE_MASK;
    end
    if (wr_lowpwr) begin
      // The low-power flags can only be cleared by software, never set.
      state_next.lowpwr = state_reg.lowpwr & reg_wdata[3:0];
    end

    // Power-save entry and watchdog clear both restart the time-out flag.
    if (wdt_clear || sleep_enter || idle_enter) begin
      state_next.cause[`RSS_BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
    end
    if (sleep_enter) begin
      state_next.cause[`RSS_BIT_SLEEP] = 1'b1;
      if (deep_sleep_en) begin
        state_next.cause[`RSS_BIT_DSLEEP] = 1'b1;
      end
    end
    if (idle_enter) begin
      state_next.cause[`RSS_BIT_IDLE] = 1'b1;
    end

    // Reset cause flags.
    if (trap_conflict) begin
      state_next.cause[`RSS_BIT_TRAP] = 1'b1;
    end
    if (illegal_any) begin
      state_next.cause[`RSS_BIT_ILLOP] = 1'b1;
    end
    if (config_mismatch) begin
      state_next.cause[`RSS_BIT_CFGMIS] = 1'b1;
    end
    if (pin_reset) begin
      state_next.cause[`RSS_BIT_PIN] = 1'b1;
    end
    if (soft_reset_req) begin
      state_next.cause[`RSS_BIT_SOFT] = 1'b1;
    end
    if (watchdog_timeout) begin
      state_next.cause[`RSS_BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
    end
    if (brownout) begin
      state_next.cause[`RSS_BIT_BROWN] = 1'b1;
    end

    // Events seen while running from the backup battery.
    if (brownout && battery_backup_active) begin
      state_next.lowpwr[`RSS_LP_BIT_VDDBOR] = 1'b1;
    end
    if (battery_por_event) begin
      state_next.lowpwr[`RSS_LP_BIT_VBPOR] = 1'b1;
    end
    if (battery_exit_event) begin
      state_next.lowpwr[`RSS_LP_BIT_VBEXIT] = 1'b1;
    end

    // Derived controls; fuses left at 1 override the software bits.
    state_next.hold_en    = state_next.cause[`RSS_BIT_HOLD] & ~retention_regulator_fuse;
    state_next.fbias_keep = state_next.cause[`RSS_BIT_FBIAS];
    state_next.wdt_en     = state_next.cause[`RSS_BIT_WDEN] | watchdog_fuse_enable;

    // Read data stand for exactly the cycle after the strobe.
    if (reg_rd) begin
      unique case (reg_addr)
        `RSS_IDX_CAUSE: begin
          state_next.rdata = state_reg.cause & `RSS_CAUSE_MASK;
        end
        `RSS_IDX_LOWPWR: begin
          state_next.rdata = {12'h000, state_reg.lowpwr};
        end
        `RSS_IDX_SOURCES: begin
          state_next.rdata = {7'h00, stretch_out, illegal_any, trap_conflict,
                              config_mismatch, brownout, watchdog_timeout,
                              soft_reset_req, pin_reset, rst};
        end
        `RSS_IDX_CONTROLS: begin
          state_next.rdata = {11'h000, watchdog_fuse_enable, retention_regulator_fuse,
                              state_reg.wdt_en, state_reg.fbias_keep,
                              state_reg.hold_en};
        end
        default: begin
          state_next.rdata = '0;
        end
      endcase
    end
  end

  // Only the power-on reset reinitialises this state; other resets leave it.
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg.cause      <= `RSS_CAUSE_POR_VAL;
      state_reg.lowpwr     <= `RSS_LP_POR_VAL;
      state_reg.rdata      <= '0;
      state_reg.hold_en    <= 1'b0;
      state_reg.fbias_keep <= 1'b0;
      state_reg.wdt_en     <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata               = state_reg.rdata;
  assign master_reset            = stretch_out;
  assign low_voltage_hold_enable = state_reg.hold_en;
  assign flash_bias_sleep_keep   = state_reg.fbias_keep;
  assign watchdog_enable         = state_reg.wdt_en;

endmodule

`default_nettype wire

// ### verif/rss_assertions.sv
// Port-level assertions for the reset source combiner.
`timescale 1ns/1ps
`default_nettype none
`include "rss_params.svh"

module rss_assertions
  import rss_pkg::*;
(
  input wire logic                   mclk,
  input wire logic                   rst,
  input wire logic                   master_clear_pin_n,
  input wire logic                   brownout_detect,
  input wire logic                   soft_reset_req,
  input wire logic                   watchdog_timeout,
  input wire logic                   config_mismatch,
  input wire logic                   trap_conflict,
  input wire logic                   illegal_opcode,
  input wire logic                   uninit_wreg_reset,
  input wire logic [`RSS_ADDR_W-1:0] reg_addr,
  input wire logic [`RSS_DATA_W-1:0] reg_wdata,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [`RSS_DATA_W-1:0] reg_rdata,
  input wire logic                   master_reset,
  input wire logic                   low_voltage_hold_enable,
  input wire logic                   watchdog_enable,
  input wire logic                   retention_regulator_fuse,
  input wire logic                   watchdog_fuse_enable
);
  logic quiet;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // Pin sources pass a synchroniser, so quiet must hold over a span, not one cycle.
  assign quiet = master_clear_pin_n & ~brownout_detect & ~soft_reset_req & ~watchdog_timeout
                 & ~config_mismatch & ~trap_conflict & ~illegal_opcode & ~uninit_wreg_reset;

  property p_src;
    (soft_reset_req | watchdog_timeout | config_mismatch | trap_conflict | illegal_opcode
     | uninit_wreg_reset) |=> master_reset;
  endproperty
  a_src: assert property (p_src) else $error("source missed by master reset");

  property p_stretch;
    trap_conflict |-> ##21 master_reset;
  endproperty
  a_stretch: assert property (p_stretch) else $error("master reset released early");

  property p_unimpl;
    $past(reg_rd) && $past(reg_addr) == `RSS_IDX_CAUSE |-> !reg_rdata[13] && !reg_rdata[11];
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented bit reads one");

  property p_no_reset;
    quiet [*4] ##0 (reg_wr && !master_reset) |=> !master_reset;
  endproperty
  a_no_reset: assert property (p_no_reset) else $error("write caused a reset");

  property p_hold;
    reg_wr && reg_addr == `RSS_IDX_CAUSE |=> low_voltage_hold_enable ==
      ($past(reg_wdata[12]) && !$past(retention_regulator_fuse));
  endproperty
  a_hold: assert property (p_hold) else $error("hold enable wrong after write");

  property p_ret_fuse;
    $past(retention_regulator_fuse) |-> !low_voltage_hold_enable;
  endproperty
  a_ret_fuse: assert property (p_ret_fuse) else $error("hold enable despite fuse");

  property p_wd_soft;
    reg_wr && reg_addr == `RSS_IDX_CAUSE |=> watchdog_enable ==
      ($past(reg_wdata[5]) || $past(watchdog_fuse_enable));
  endproperty
  a_wd_soft: assert property (p_wd_soft) else $error("watchdog enable wrong");

  property p_wd_fuse;
    $past(watchdog_fuse_enable) |-> watchdog_enable;
  endproperty
  a_wd_fuse: assert property (p_wd_fuse) else $error("watchdog off despite fuse");
endmodule

bind rss_top rss_assertions u_rss_assertions (
  .mclk, .rst, .master_clear_pin_n, .brownout_detect, .soft_reset_req, .watchdog_timeout,
  .config_mismatch, .trap_conflict, .illegal_opcode, .uninit_wreg_reset, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .master_reset, .low_voltage_hold_enable,
  .watchdog_enable, .retention_regulator_fuse, .watchdog_fuse_enable
);

`default_nettype wire

// ### verif/rss_partner.sv
// Model of the reset-source logic that raises one source on request.
`timescale 1ns/1ps
`default_nettype none

module rss_partner (
  input  wire logic       mclk,
  input  wire logic       fire,
  input  wire logic [3:0] sel,
  output logic            master_clear_pin_n,
  output logic            soft_reset_req,
  output logic            watchdog_timeout,
  output logic            brownout_detect,
  output logic            config_mismatch,
  output logic            trap_conflict,
  output logic            illegal_opcode,
  output logic            uninit_wreg_reset
);
  logic [7:0] src = 8'h00;

  // Four cycles lets the pin synchroniser catch it while keeping the run short.
  always @(posedge mclk) begin
    if (fire) begin
      src <= 8'h01 << sel;
      repeat (4) @(posedge mclk);
      src <= 8'h00;
    end
  end

  assign master_clear_pin_n = ~src[0];
  assign {uninit_wreg_reset, illegal_opcode, trap_conflict, config_mismatch,
          brownout_detect, watchdog_timeout, soft_reset_req} = src[7:1];
endmodule

`default_nettype wire

// ### verif/tb_top.sv
// Self-checking testbench for the reset source combiner.
`timescale 1ns/1ps
`default_nettype none
`include "rss_params.svh"

module tb_top;
  import rss_pkg::*;

  localparam logic [15:0] flag_bits [8] = '{16'h0080, 16'h0040, 16'h0010, 16'h0002,
                                            16'h0200, 16'h8000, 16'h4000, 16'h4000};
  logic                   mclk;
  logic                   rst = 1'b1;
  logic                   fire = 1'b0;
  logic                   reg_wr = 1'b0;
  logic                   reg_rd = 1'b0;
  logic                   rd_d = 1'b0;
  logic                   retention_regulator_fuse = 1'b0;
  logic                   watchdog_fuse_enable = 1'b0;
  logic [3:0]             sel = 4'h0;
  logic [6:0]             misc = 7'h00;
  logic [`RSS_ADDR_W-1:0] reg_addr = 4'h0;
  logic [`RSS_DATA_W-1:0] reg_wdata = 16'h0000;
  logic [`RSS_DATA_W-1:0] reg_rdata;
  logic [`RSS_DATA_W-1:0] w;
  logic [`RSS_DATA_W-1:0] expq[$];
  logic                   master_clear_pin_n, brownout_detect, soft_reset_req;
  logic                   watchdog_timeout, config_mismatch, trap_conflict;
  logic                   illegal_opcode, uninit_wreg_reset, master_reset;
  logic                   low_voltage_hold_enable, watchdog_enable, flash_bias_sleep_keep;
  int                     num_errors = 0;
  int                     cmp_count = 0;
  int                     n;

  rss_top u_rss_top (
    .mclk, .rst, .master_clear_pin_n, .brownout_detect, .soft_reset_req, .watchdog_timeout,
    .config_mismatch, .trap_conflict, .illegal_opcode, .uninit_wreg_reset,
    .sleep_enter(misc[0]), .idle_enter(misc[1]), .deep_sleep_en(misc[2]), .wdt_clear(misc[3]),
    .battery_backup_active(misc[4]), .battery_por_event(misc[5]),
    .battery_exit_event(misc[6]), .retention_regulator_fuse, .watchdog_fuse_enable,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .master_reset,
    .low_voltage_hold_enable, .flash_bias_sleep_keep, .watchdog_enable
  );

  rss_partner u_rss_partner (
    .mclk, .fire, .sel, .master_clear_pin_n, .soft_reset_req, .watchdog_timeout,
    .brownout_detect, .config_mismatch, .trap_conflict, .illegal_opcode, .uninit_wreg_reset
  );

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic rd, input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_wr <= wr;
    reg_rd <= rd;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    expq.push_back(e);
    bus(1'b0, 1'b1, a, 16'h0000);
  endtask

  task automatic pulse(input logic [6:0] m);
    @(posedge mclk);
    misc <= m;
    @(posedge mclk);
    misc <= 7'h00;
  endtask

  // Fires one source and counts the cycles that master reset is seen high.
  task automatic hit(input logic [3:0] s, input logic [15:0] e);
    @(posedge mclk);
    fire <= 1'b1;
    sel <= s;
    @(posedge mclk);
    fire <= 1'b0;
    n = 0;
    repeat (40) begin
      @(posedge mclk);
      if (master_reset === 1'b1) n++;
    end
    check(16'(n), 16'h0018);
    rd(4'h0, e);
  endtask

  always @(posedge mclk) begin
    if (rd_d) check(reg_rdata, expq.pop_front());
    rd_d <= reg_rd;
  end

  task automatic test_done;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #50000;
    num_errors++;
    $display("ERROR t=%0t watchdog expired", $time);
    test_done();
  end

  initial begin
    void'($urandom(32'h2AE4));
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    rd(4'h0, 16'h0003);
    rd(4'h1, 16'h000E);
    rd(4'h2, 16'h0100);
    bus(1'b1, 1'b0, 4'h0, 16'hFFFF);
    rd(4'h0, 16'hD7FF);
    bus(1'b1, 1'b0, 4'h5, 16'h0000);
    rd(4'h0, 16'hD7FF);
    rd(4'h9, 16'h0000);
    // The power-on stretch must be over, or it adds to the counted reset length.
    repeat (30) @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, 1'b0, 4'h0, 16'h1100);
      hit(4'(i), 16'h1100 | flag_bits[i]);
    end
    for (int i = 0; i < 8; i++) begin
      w = 16'($urandom());
      @(posedge mclk);
      retention_regulator_fuse <= w[0];
      watchdog_fuse_enable <= w[1];
      bus(1'b1, 1'b0, 4'h0, w);
      rd(4'h0, w & 16'hD7FF);
      check(16'(flash_bias_sleep_keep), 16'(w[8]));
      rd(4'h3, {11'h0, w[1:0], w[5] | w[1], w[8], w[12] & ~w[0]});
    end
    bus(1'b1, 1'b0, 4'h0, 16'h0010);
    bus(1'b1, 1'b0, 4'h1, 16'h0000);
    pulse(7'h08);
    rd(4'h0, 16'h0000);
    bus(1'b1, 1'b0, 4'h0, 16'h0010);
    pulse(7'h05);
    pulse(7'h02);
    pulse(7'h60);
    rd(4'h0, 16'h040C);
    rd(4'h1, 16'h0003);
    @(posedge mclk);
    misc <= 7'h10;
    hit(4'h3, 16'h040E);
    rd(4'h1, 16'h000B);
    bus(1'b1, 1'b0, 4'h1, 16'h0001);
    rd(4'h1, 16'h0001);
    rst <= 1'b1;
    misc <= 7'h00;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    rd(4'h0, 16'h0003);
    repeat (3) @(posedge mclk);
    test_done();
  end
endmodule

`default_nettype wire
